// [inc/adc_irq_pkg.sv]
package adc_irq_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFF_ENABLE = 4'h0;
  localparam logic [3:0] OFF_FLAGS = 4'h4;
  localparam logic [3:0] OFF_VECTOR = 4'h8;
  localparam logic [3:0] OFF_OVF_STATUS = 4'hC;
  localparam int SLOTS = 16;

  // ----------------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] VECTOR_RESET = 16'h0000;
  localparam int OVF_MEM_BIT = 0;
  localparam int OVF_TIME_BIT = 1;

  // ----------------------------------------------------------------------
  // Vector codes
  // ----------------------------------------------------------------------
  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [15:0] VEC_MEM_OVF = 16'h0002;
  localparam logic [15:0] VEC_TIME_OVF = 16'h0004;
  localparam logic [15:0] VEC_SLOT0 = 16'h0006;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_e;

endpackage

// [core/adc_result_irq_logic.sv]
`timescale 1ns/10ps
module adc_result_irq_logic (
  input wire logic core_clk, // System clock, 10 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [15:0] resultWrite, // Pulse per slot: new result stored.
  input wire logic [15:0] resultAccess, // Pulse per slot: software access.
  input wire logic memOverflowEvent, // Pulse: result overwritten unread.
  input wire logic timeOverflowEvent, // Pulse: conversion time overflow.
  input wire logic [3:0] awaddr, // AXI write address.
  input wire logic awvalid, // AXI write address valid.
  output logic awready, // AXI write address ready.
  input wire logic [31:0] wdata, // AXI write data.
  input wire logic [3:0] wstrb, // AXI write strobes.
  input wire logic wvalid, // AXI write data valid.
  output logic wready, // AXI write data ready.
  output logic [1:0] bresp, // AXI write response.
  output logic bvalid, // AXI write response valid.
  input wire logic bready, // AXI write response ready.
  input wire logic [3:0] araddr, // AXI read address.
  input wire logic arvalid, // AXI read address valid.
  output logic arready, // AXI read address ready.
  output logic [31:0] rdata, // AXI read data.
  output logic [1:0] rresp, // AXI read response.
  output logic rvalid, // AXI read data valid.
  input wire logic rready, // AXI read data ready.
  output logic irqRequest // Level interrupt request.
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] enable;
    logic [15:0] flags;
    logic [1:0] ovf;
    logic [15:0] vector;
    logic awHeld;
    logic [3:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    adc_irq_pkg::wr_state_e wrState;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } state_s;

  state_s st_reg;
  state_s st_next;

  function automatic logic [15:0] vectorCode(input logic [1:0] ovf,
                                              input logic [15:0] flags);
    logic [15:0] code;
    code = adc_irq_pkg::VEC_NONE;
    for (int i = adc_irq_pkg::SLOTS - 1; i >= 0; i--) begin
      if (flags[i]) begin
        code = 16'(adc_irq_pkg::VEC_SLOT0 + 16'(2 * i));
      end
    end
    if (ovf[adc_irq_pkg::OVF_TIME_BIT]) begin
      code = adc_irq_pkg::VEC_TIME_OVF;
    end
    if (ovf[adc_irq_pkg::OVF_MEM_BIT]) begin
      code = adc_irq_pkg::VEC_MEM_OVF;
    end
    return code;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
    logic [15:0] v;
    v = old;
    if (s[0]) begin
      v[7:0] = d[7:0];
    end
    if (s[1]) begin
      v[15:8] = d[15:8];
    end
    return v;
  endfunction

  logic doWrite;
  logic doRead;
  logic readHit;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [15:0] sw;
    logic [1:0] ovfClr;
    sw = 16'h0000;
    ovfClr = 2'h0;
    st_next = st_reg;
    doWrite = 1'b0;
    doRead = arvalid && (!st_reg.rValid || rready);
    readHit = 1'b1;
    if (awvalid && awready) begin
      st_next.awHeld = 1'b1;
      st_next.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      st_next.wHeld = 1'b1;
      st_next.wData = wdata;
      st_next.wStrb = wstrb;
    end
    // Flag and enable updates; software writes first so hardware sets win.
    case (st_reg.wrState)
      adc_irq_pkg::WR_IDLE: begin
        if (st_reg.awHeld && st_reg.wHeld) begin
          doWrite = 1'b1;
          st_next.awHeld = 1'b0;
          st_next.wHeld = 1'b0;
          st_next.wrState = adc_irq_pkg::WR_RESP;
          st_next.bResp = adc_irq_pkg::RESP_OKAY;
          case (st_reg.awAddr)
            adc_irq_pkg::OFF_ENABLE:
              st_next.enable = merge16(st_reg.enable, st_reg.wData,
                                       st_reg.wStrb);
            adc_irq_pkg::OFF_FLAGS:
              sw = merge16(st_reg.flags, st_reg.wData, st_reg.wStrb);
            adc_irq_pkg::OFF_VECTOR: begin
              st_next.bResp = adc_irq_pkg::RESP_SLVERR;
            end
            adc_irq_pkg::OFF_OVF_STATUS: begin
              if (st_reg.wStrb[0]) begin
                ovfClr = st_reg.wData[1:0];
              end
            end
            default: st_next.bResp = adc_irq_pkg::RESP_SLVERR;
          endcase
        end
      end
      adc_irq_pkg::WR_RESP: begin
        if (bready) begin
          st_next.wrState = adc_irq_pkg::WR_IDLE;
        end
      end
      default: st_next.wrState = adc_irq_pkg::WR_IDLE;
    endcase
    if (!(doWrite && st_reg.awAddr == adc_irq_pkg::OFF_FLAGS)) begin
      sw = st_reg.flags;
    end
    st_next.flags = (sw & ~resultAccess) | resultWrite;
    st_next.ovf = (st_reg.ovf & ~ovfClr)
                | {timeOverflowEvent, memOverflowEvent};
    st_next.vector = vectorCode(st_next.ovf, st_next.flags);
    if (st_reg.rValid && rready) begin
      st_next.rValid = 1'b0;
    end
    if (doRead) begin
      st_next.rValid = 1'b1;
      st_next.rResp = adc_irq_pkg::RESP_OKAY;
      case (araddr)
        adc_irq_pkg::OFF_ENABLE: st_next.rData = {16'h0000, st_reg.enable};
        adc_irq_pkg::OFF_FLAGS: st_next.rData = {16'h0000, st_reg.flags};
        adc_irq_pkg::OFF_VECTOR: st_next.rData = {16'h0000, st_reg.vector};
        adc_irq_pkg::OFF_OVF_STATUS: st_next.rData = {30'h0, st_reg.ovf};
        default: begin
          readHit = 1'b0;
          st_next.rData = 32'h0000_0000;
          st_next.rResp = adc_irq_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{enable: adc_irq_pkg::ENABLE_RESET,
                  flags: adc_irq_pkg::FLAGS_RESET,
                  ovf: 2'h0,
                  vector: adc_irq_pkg::VECTOR_RESET,
                  awHeld: 1'b0, awAddr: 4'h0,
                  wHeld: 1'b0, wData: 32'h0000_0000, wStrb: 4'h0,
                  wrState: adc_irq_pkg::WR_IDLE,
                  bResp: 2'h0, rValid: 1'b0,
                  rData: 32'h0000_0000, rResp: 2'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign awready = !st_reg.awHeld;
  assign wready = !st_reg.wHeld;
  assign bvalid = st_reg.wrState == adc_irq_pkg::WR_RESP;
  assign bresp = st_reg.bResp;
  assign arready = !st_reg.rValid || rready;
  assign rvalid = st_reg.rValid;
  assign rdata = st_reg.rData;
  assign rresp = st_reg.rResp;
  assign irqRequest = (|st_reg.ovf)
                   || (|(st_reg.flags & st_reg.enable));

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_flag_set_event: assert property (
    resultWrite[0] |=> st_reg.flags[0])
    else $error("Slot flag not set by result write.");
  a_flag_clear_access: assert property (
    resultAccess[3] && !resultWrite[3] && !doWrite |=> !st_reg.flags[3])
    else $error("Slot flag not cleared by access.");
  a_irq_masked_slot: assert property (
    st_reg.ovf == 2'h0 && (st_reg.flags & st_reg.enable) == 16'h0000
    |-> !irqRequest)
    else $error("Interrupt raised with nothing enabled.");
  a_irq_enabled_slot: assert property (
    st_reg.flags[5] && st_reg.enable[5] |-> irqRequest)
    else $error("Enabled flag did not raise interrupt.");
  a_vector_mem_top: assert property (
    st_reg.ovf[0] |-> st_reg.vector == 16'h0002)
    else $error("Memory overflow not top priority.");
  a_vector_none: assert property (
    st_reg.ovf == 2'h0 && st_reg.flags == 16'h0000 |-> st_reg.vector == 16'h0)
    else $error("Vector not zero when idle.");
  a_vector_slot_last: assert property (
    st_reg.ovf == 2'h0 && st_reg.flags == 16'h8000
    |-> st_reg.vector == 16'h0024)
    else $error("Lowest slot code wrong.");
  a_flag_sw_write: assert property (
    doWrite && st_reg.awAddr == 4'h4 && st_reg.wStrb[0]
    && resultWrite == 16'h0 && resultAccess == 16'h0
    |=> st_reg.flags[7:0] == $past(st_reg.wData[7:0]))
    else $error("Software flag write not applied.");
  a_write_answer: assert property (
    st_reg.awHeld && st_reg.wHeld && !bvalid |=> bvalid)
    else $error("Write response late.");

  c_slot_irq: cover property (resultWrite[2] ##1 irqRequest);
  c_ovf_vector: cover property (st_reg.vector == 16'h0004);
  c_read_vector: cover property (doRead && readHit && araddr == 4'h8);

endmodule

// [verification/adc_result_irq_logic_tb.sv]
`timescale 1ns/10ps
module adc_result_irq_logic_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] resultWrite = 16'h0000;
  logic [15:0] resultAccess = 16'h0000;
  logic memOverflowEvent = 1'b0;
  logic timeOverflowEvent = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irqRequest;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] en = 16'h0000, fl = 16'h0000;
  logic [1:0] ov = 2'h0;
  int fails = 0, checked = 0, cycles = 0;
  int seed = 32'h3711;
  logic [34:0] rdQ[$];
  logic [1:0] wrQ[$];
  localparam logic [1:0] OK = adc_irq_pkg::RESP_OKAY;
  localparam logic [1:0] SLV = adc_irq_pkg::RESP_SLVERR;

  always #50 core_clk = ~core_clk;

  adc_result_irq_logic adc_result_irq_logic_i (.core_clk(core_clk),
    .rst(rst), .resultWrite(resultWrite), .resultAccess(resultAccess),
    .memOverflowEvent(memOverflowEvent),
    .timeOverflowEvent(timeOverflowEvent), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irqRequest(irqRequest));

  // ---------------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------------
  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [34:0] got, input logic [34:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // The interrupt level rides along with each read, so it is compared
  // at the very edge that hands over the read data.
  always @(posedge core_clk) begin
    cycles++;
    if (rvalid === 1'b1 && rready === 1'b1) begin
      cmp({irqRequest, rresp, rdata}, rdQ.pop_front());
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      cmp({33'h0, bresp}, {33'h0, wrQ.pop_front()});
    end
    if (cycles == 5000) begin
      fails++;
      close_out();
    end
  end

  // ---------------------------------------------------------------------
  // Bus and event drivers
  // ---------------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge core_clk);
    wrQ.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [34:0] e);
    @(posedge core_clk);
    rdQ.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic ev(input logic [15:0] w, input logic [15:0] a,
                    input logic [1:0] o);
    @(posedge core_clk);
    resultWrite <= w;
    resultAccess <= a;
    memOverflowEvent <= o[0];
    timeOverflowEvent <= o[1];
    @(posedge core_clk);
    resultWrite <= 16'h0000;
    resultAccess <= 16'h0000;
    memOverflowEvent <= 1'b0;
    timeOverflowEvent <= 1'b0;
  endtask

  function automatic logic [34:0] ex(input logic [1:0] r,
                                     input logic [15:0] v);
    ex = {|(fl & en) | |ov, r, 16'h0000, v};
  endfunction

  function automatic logic [15:0] vecOf();
    vecOf = adc_irq_pkg::VEC_NONE;
    for (int i = 15; i >= 0; i--) begin
      if (fl[i]) vecOf = adc_irq_pkg::VEC_SLOT0 + 16'(2 * i);
    end
    if (ov[1]) vecOf = adc_irq_pkg::VEC_TIME_OVF;
    if (ov[0]) vecOf = adc_irq_pkg::VEC_MEM_OVF;
  endfunction

  task automatic chkAll();
    rd(adc_irq_pkg::OFF_ENABLE, ex(OK, en));
    rd(adc_irq_pkg::OFF_FLAGS, ex(OK, fl));
    rd(adc_irq_pkg::OFF_VECTOR, ex(OK, vecOf()));
    rd(adc_irq_pkg::OFF_OVF_STATUS, ex(OK, {14'h0, ov}));
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    chkAll();
    rd(4'h2, ex(SLV, 16'h0000));
    wr(adc_irq_pkg::OFF_VECTOR, 32'h0000FFFF, SLV);
    chkAll();
    $display("reset and access test done");
    en = 16'hFFFF;
    wr(adc_irq_pkg::OFF_ENABLE, 32'h0000FFFF, OK);
    for (int k = 0; k < 16; k++) begin
      fl = 16'h0001 << k;
      ev(fl, 16'h0000, 2'h0);
      chkAll();
      fl = 16'h0000;
      ev(16'h0000, 16'h0001 << k, 2'h0);
      chkAll();
    end
    $display("slot walk test done");
    repeat (8) begin
      en = 16'($random(seed));
      fl = 16'($random(seed));
      wr(adc_irq_pkg::OFF_ENABLE, {16'($random(seed)), en}, OK);
      wr(adc_irq_pkg::OFF_FLAGS, {16'h0000, fl}, OK);
      chkAll();
    end
    $display("random priority test done");
    // Only the low byte lane is enabled, so the upper flags must survive.
    fl = {fl[15:8], 8'h5A};
    wstrb <= 4'h1;
    wr(adc_irq_pkg::OFF_FLAGS, 32'hFFFF_A55A, OK);
    wstrb <= 4'hF;
    chkAll();
    $display("byte strobe test done");
    fl = 16'h0000;
    wr(adc_irq_pkg::OFF_FLAGS, 32'h0, OK);
    ov = 2'h2;
    ev(16'h0000, 16'h0000, 2'h2);
    chkAll();
    ov = 2'h3;
    fl = 16'h8000;
    ev(16'h8000, 16'h0000, 2'h1);
    chkAll();
    ov = 2'h2;
    wr(adc_irq_pkg::OFF_OVF_STATUS, 32'h1, OK);
    chkAll();
    ov = 2'h0;
    wr(adc_irq_pkg::OFF_OVF_STATUS, 32'h2, OK);
    chkAll();
    $display("overflow test done");
    close_out();
  end
endmodule
